// ==== zx_top.sv ====
// Zero-cross detector logic with Wishbone register slave
//
// Summary of operation
// - Front end reports sink or source decision as the single input level.
// - Without inversion, output is high while sinking, low while sourcing.
// - Polarity control inverts the output: high means sourcing.
// - Adjusted output feeds timer gate, clock and reset sources.
// - Rising and falling detectors watch the polarity-adjusted output.
// - Flag sets on enabled rising or enabled falling edge.
// - CPU request needs flag, its enable, peripheral and global enables.
// - Writing a changed polarity sets the flag regardless of soft enable.
// - An edge in the same cycle as a clear keeps the flag set.
// - Fuse clear: always active; fuse set: active only with soft enable.
// - Control: enable bit 7, output bit 5, polarity 4, rise 1, fall 0.
// - Logic keeps running unchanged during sleep.
`timescale 1ns/1ps
`default_nettype none
`include "zx_defs.svh"
module zx_top #(
    parameter int ADDR_W      = 14,
    parameter int SYNC_STAGES = 2
) (
    // System
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [ADDR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output var  logic [31:0] WB_DAT_O,
    output var  logic        WB_ACK_O,
    // Front end
    input  wire logic        SINK_ACTIVE,
    input  wire logic        FUSE_CFG,
    output var  logic        DETECT_ACTIVE,
    // Timer sources
    output var  logic        TMR16_GATE,
    output var  logic        TMR8_CLK,
    output var  logic        TMR8_RST,
    // Interrupts
    output var  logic        CPU_IRQ,
    output var  logic        IRQ
);
    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    ////////////////////////////////////////////////////////////////////////
    // Address decode is fixed to a 14-bit byte address
    initial begin
        if (ADDR_W != 14) begin
            $error("zx_top needs a 14-bit byte address");
        end
        if (SYNC_STAGES < 2) begin
            $error("zx_top needs at least two synchroniser stages");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////
    zx_pkg::zx_wb_e   wb_state_r;
    zx_pkg::zx_wb_e   wb_state_nxt;
    zx_pkg::zx_byte_t ctrl_r;
    zx_pkg::zx_byte_t ctrl_nxt;
    zx_pkg::zx_byte_t rd_byte;
    logic [31:0]      rd_data_r;
    logic             ack_r;
    logic             flag_r;
    logic             flag_nxt;
    logic             ie_r;
    logic             periph_en_r;
    logic             global_en_r;
    logic [`ZX_STAT_W-1:0] stat_r;
    logic [`ZX_STAT_W-1:0] stat_nxt;
    logic [`ZX_STAT_W-1:0] stat_set;
    logic [`ZX_STAT_W-1:0] mask_r;
    logic             polchg_r;
    logic             cpu_irq_r;
    logic             irq_r;
    logic             sink_sync;
    logic             active;
    logic             req;
    logic             wr_stb;
    logic             lane0;
    logic [11:0]      idx;
    logic             word_ok;
    logic             hit_ctrl;
    logic             hit_flag;
    logic             hit_enable;
    logic             hit_global;
    logic             hit_stat;
    logic             hit_mask;
    logic             wr_ctrl;
    logic             wr_flag;
    logic             wr_enable;
    logic             wr_global;
    logic             wr_stat;
    logic             wr_mask;
    logic             pol_written;
    logic             edge_set;
    logic             flag_clr;
    zx_pkg::zx_byte_t wdat;

    // Edge stage results shared by the flag and status logic
    zx_evt_if evt ();

    ////////////////////////////////////////////////////////////////////////
    // Front end input and detector enable
    ////////////////////////////////////////////////////////////////////////
    // Decision is asynchronous to CLK; only the last stage is read
    zx_sync #(
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .clk    (CLK),
        .arst_n (ARST_N),
        .d      (SINK_ACTIVE),
        .q      (sink_sync)
    );

    // Fuse clear forces the detector on
    assign active = ~FUSE_CFG | ctrl_r[`ZX_CTRL_SOFT_EN];

    zx_edge u_edge (
        .clk      (CLK),
        .arst_n   (ARST_N),
        .active   (active),
        .polarity_invert      (ctrl_r[`ZX_CTRL_POL]),
        .sink_lvl (sink_sync),
        .evt      (evt)
    );

    assign DETECT_ACTIVE = active;

    // No sleep input: the logic runs on regardless
    // One registered level feeds all three timer inputs, so they never skew
    assign TMR16_GATE = evt.out_lvl;
    assign TMR8_CLK   = evt.out_lvl;
    assign TMR8_RST   = evt.out_lvl;

    ////////////////////////////////////////////////////////////////////////
    // Wishbone decode
    ////////////////////////////////////////////////////////////////////////
    // Taken only while idle, so a held strobe is not taken twice
    assign req     = WB_CYC_I & WB_STB_I & (wb_state_r == zx_pkg::ZX_WB_IDLE);
    assign wr_stb  = req & WB_WE_I;
    assign lane0   = WB_SEL_I[0];
    assign idx     = WB_ADR_I[13:2];
    assign word_ok = (WB_ADR_I[1:0] == 2'h0);
    assign wdat    = WB_DAT_I[7:0];

    // Misaligned addresses hit nothing and read back zero
    assign hit_ctrl   = word_ok & (idx == `ZX_IDX_CTRL);
    assign hit_flag   = word_ok & (idx == `ZX_IDX_FLAG);
    assign hit_enable = word_ok & (idx == `ZX_IDX_ENABLE);
    assign hit_global = word_ok & (idx == `ZX_IDX_GLOBAL);
    assign hit_stat   = word_ok & (idx == `ZX_IDX_STAT);
    assign hit_mask   = word_ok & (idx == `ZX_IDX_MASK);

    // Only byte lane 0 carries register data
    assign wr_ctrl   = wr_stb & lane0 & hit_ctrl;
    assign wr_flag   = wr_stb & lane0 & hit_flag;
    assign wr_enable = wr_stb & lane0 & hit_enable;
    assign wr_global = wr_stb & lane0 & hit_global;
    assign wr_stat   = wr_stb & lane0 & hit_stat;
    assign wr_mask   = wr_stb & lane0 & hit_mask;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake
    ////////////////////////////////////////////////////////////////////////
    // Every access is acknowledged one cycle after it is taken, mapped or not
    always_comb begin
        wb_state_nxt = wb_state_r;
        case (wb_state_r)
            zx_pkg::ZX_WB_IDLE: begin
                if (WB_CYC_I && WB_STB_I) begin
                    wb_state_nxt = zx_pkg::ZX_WB_ACK;
                end
            end
            zx_pkg::ZX_WB_ACK: begin
                wb_state_nxt = zx_pkg::ZX_WB_IDLE;
            end
            default: begin
                wb_state_nxt = zx_pkg::ZX_WB_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wb_state_r <= zx_pkg::ZX_WB_IDLE;
            ack_r      <= 1'b0;
        end else begin
            wb_state_r <= wb_state_nxt;
            ack_r      <= req;
        end
    end

    assign WB_ACK_O = ack_r;

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    ////////////////////////////////////////////////////////////////////////
    // Output bit is read live from the edge stage, not stored in the register
    always_comb begin
        rd_byte = 8'h00;
        if (hit_ctrl) begin
            rd_byte = ctrl_r;
            rd_byte[`ZX_CTRL_OUT] = evt.out_lvl;
        end else if (hit_flag) begin
            rd_byte[`ZX_FLAG_BIT] = flag_r;
        end else if (hit_enable) begin
            rd_byte[`ZX_ENABLE_BIT] = ie_r;
        end else if (hit_global) begin
            rd_byte[`ZX_GLOBAL_PERIPH] = periph_en_r;
            rd_byte[`ZX_GLOBAL_ALL]    = global_en_r;
        end else if (hit_stat) begin
            rd_byte[`ZX_STAT_W-1:0] = stat_r;
        end else if (hit_mask) begin
            rd_byte[`ZX_STAT_W-1:0] = mask_r;
        end
    end

    // Captured at the taking edge, stands while ack is high
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_data_r <= 32'h0000_0000;
        end else if (req) begin
            rd_data_r <= {24'h00_0000, rd_byte};
        end
    end

    assign WB_DAT_O = rd_data_r;

    ////////////////////////////////////////////////////////////////////////
    // Control register
    ////////////////////////////////////////////////////////////////////////
    // Polarity change is held one cycle and then sets the flag like an edge
    assign ctrl_nxt    = wr_ctrl ? (wdat & `ZX_CTRL_WMASK) : ctrl_r;
    assign pol_written = wr_ctrl & (wdat[`ZX_CTRL_POL] != ctrl_r[`ZX_CTRL_POL]);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_r   <= `ZX_CTRL_RESET;
            polchg_r <= 1'b0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            polchg_r <= pol_written;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossing flag
    ////////////////////////////////////////////////////////////////////////
    // Edge enables gate only the flag; status bits record every edge
    assign edge_set = (evt.rise & ctrl_r[`ZX_CTRL_RISE_EN])
                    | (evt.fall & ctrl_r[`ZX_CTRL_FALL_EN])
                    | polchg_r;
    assign flag_clr = wr_flag & wdat[`ZX_FLAG_BIT];
    // Set has priority over a clear in the same cycle
    assign flag_nxt = edge_set | (flag_r & ~flag_clr);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enables
    ////////////////////////////////////////////////////////////////////////
    // Interrupt enables, plain read and write
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ie_r <= 1'b0;
        end else if (wr_enable) begin
            ie_r <= wdat[`ZX_ENABLE_BIT];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            periph_en_r <= 1'b0;
            global_en_r <= 1'b0;
        end else if (wr_global) begin
            periph_en_r <= wdat[`ZX_GLOBAL_PERIPH];
            global_en_r <= wdat[`ZX_GLOBAL_ALL];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky event status and mask
    ////////////////////////////////////////////////////////////////////////
    assign stat_set[`ZX_STAT_RISE]   = evt.rise;
    assign stat_set[`ZX_STAT_FALL]   = evt.fall;
    assign stat_set[`ZX_STAT_POLCHG] = polchg_r;

    // Write one clears; a new event wins
    assign stat_nxt = stat_set
                    | (stat_r & ~(wr_stat ? wdat[`ZX_STAT_W-1:0] : 3'h0));

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stat_r <= 3'h0;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // Mask gates only the level output, never the status bits
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mask_r <= 3'h0;
        end else if (wr_mask) begin
            mask_r <= wdat[`ZX_STAT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt outputs
    ////////////////////////////////////////////////////////////////////////
    // Next-state values used so the outputs rise with their flags
    // A mask write reaches the level output one cycle later
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cpu_irq_r <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            cpu_irq_r <= flag_nxt & ie_r & periph_en_r & global_en_r;
            irq_r     <= |(stat_nxt & mask_r);
        end
    end

    assign CPU_IRQ = cpu_irq_r;
    assign IRQ     = irq_r;

    // Pull-up stays off under software control outside this block
endmodule // zx_top
`default_nettype wire

// ==== zx_defs.svh ====
// Register indices, field positions and reset values of the zero-cross logic
`ifndef ZX_DEFS_SVH
`define ZX_DEFS_SVH

// Register indices; byte address is four times the index
`define ZX_IDX_CTRL       12'h0EC5
`define ZX_IDX_FLAG       12'h0EC6
`define ZX_IDX_ENABLE     12'h0EC7
`define ZX_IDX_GLOBAL     12'h0EC8
`define ZX_IDX_STAT       12'h0EC9
`define ZX_IDX_MASK       12'h0ECA

// Control register fields
`define ZX_CTRL_SOFT_EN   7
`define ZX_CTRL_OUT       5
`define ZX_CTRL_POL       4
`define ZX_CTRL_RISE_EN   1
`define ZX_CTRL_FALL_EN   0
`define ZX_CTRL_RESET     8'h00
`define ZX_CTRL_WMASK     8'h93

// Flag, enable and global enable fields
`define ZX_FLAG_BIT       0
`define ZX_ENABLE_BIT     0
`define ZX_GLOBAL_PERIPH  0
`define ZX_GLOBAL_ALL     1

// Sticky event status and mask fields
`define ZX_STAT_RISE      0
`define ZX_STAT_FALL      1
`define ZX_STAT_POLCHG    2
`define ZX_STAT_W         3

`endif

// ==== zx_pkg.sv ====
// Types shared by the zero-cross logic
package zx_pkg;
    typedef enum logic {ZX_WB_IDLE, ZX_WB_ACK} zx_wb_e;
    typedef logic [7:0] zx_byte_t;
endpackage

// ==== zx_evt_if.sv ====
// Level and edge pulses from the edge detector to the top
`timescale 1ns/1ps
`default_nettype none
interface zx_evt_if;
    logic out_lvl;
    logic rise;
    logic fall;
    modport src (output out_lvl, output rise, output fall);
    modport dst (input out_lvl, input rise, input fall);
endinterface
`default_nettype wire

// ==== zx_sync.sv ====
// Multi-stage synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module zx_sync #(
    parameter int STAGES = 2
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Level in and out
    input  wire logic d,
    output var  logic q
);
    logic [STAGES-1:0] chain_r;

    initial begin
        if (STAGES < 2) begin
            $error("zx_sync needs at least two stages");
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chain_r <= '0;
        end else begin
            chain_r <= {chain_r[STAGES-2:0], d};
        end
    end

    assign q = chain_r[STAGES-1];
endmodule // zx_sync
`default_nettype wire

// ==== zx_edge.sv ====
// Polarity adjust and rising and falling edge detection
`timescale 1ns/1ps
`default_nettype none
module zx_edge (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Control
    input  wire logic active,
    input  wire logic polarity_invert,
    input  wire logic sink_lvl,
    // Result
    zx_evt_if.src     evt
);
    logic out_nxt;
    logic out_r;
    logic rise_r;
    logic fall_r;

    // Polarity applied before the edge detectors
    assign out_nxt = (active & sink_lvl) ^ polarity_invert;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_r  <= 1'b0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end else begin
            out_r  <= out_nxt;
            rise_r <= out_nxt & ~out_r;
            fall_r <= ~out_nxt & out_r;
        end
    end

    assign evt.out_lvl = out_r;
    assign evt.rise    = rise_r;
    assign evt.fall    = fall_r;
endmodule // zx_edge
`default_nettype wire

// ==== zx_front_model.sv ====
// Front end comparator model for the zero-cross bench
`timescale 1ns/1ps
`default_nettype none
module zx_front_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Pin and enable
    input  wire logic pin_above,
    input  wire logic active,
    // Decision
    output var  logic sink
);
    // No weak pull-up, decision follows the comparator alone while active
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sink <= 1'b0;
        end else if (active) begin
            sink <= pin_above;
        end else begin
            sink <= ~sink; // Released pin, no valid level
        end
    end
endmodule // zx_front_model
`default_nettype wire

// ==== zx_top_sva.sv ====
// Concurrent checks on the zero-cross logic ports
`timescale 1ns/1ps
`default_nettype none
`include "zx_defs.svh"
module zx_top_sva #(
    parameter int ADDR_W = 14
) (
    // System
    input wire logic              CLK,
    input wire logic              ARST_N,
    // Wishbone
    input wire logic              WB_CYC_I,
    input wire logic              WB_STB_I,
    input wire logic              WB_WE_I,
    input wire logic [ADDR_W-1:0] WB_ADR_I,
    input wire logic [3:0]        WB_SEL_I,
    input wire logic [31:0]       WB_DAT_I,
    input wire logic [31:0]       WB_DAT_O,
    input wire logic              WB_ACK_O,
    // Front end, timers, interrupts
    input wire logic              SINK_ACTIVE,
    input wire logic              FUSE_CFG,
    input wire logic              DETECT_ACTIVE,
    input wire logic              TMR16_GATE,
    input wire logic              TMR8_CLK,
    input wire logic              TMR8_RST,
    input wire logic              CPU_IRQ,
    input wire logic              IRQ
);
    logic [3:0] hist_r;
    logic [2:0] quiet_r;
    logic       act_r;
    wire  logic bus_wr = WB_CYC_I && WB_STB_I && WB_WE_I;

    // Input history and cycles since last write or activity change
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hist_r  <= 4'h0;
            quiet_r <= 3'h0;
            act_r   <= 1'b0;
        end else begin
            hist_r <= {hist_r[2:0], SINK_ACTIVE};
            act_r  <= DETECT_ACTIVE;
            if (bus_wr || act_r != DETECT_ACTIVE) quiet_r <= 3'h0;
            else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    ack_latency_a: assert property ($rose(WB_STB_I) && WB_CYC_I |=> WB_ACK_O)
        else $error("ack late");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (WB_ACK_O |-> $past(WB_STB_I) && $past(WB_CYC_I))
        else $error("ack without request");
    rdata_zero_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    out_fanout_a: assert property (TMR8_CLK == TMR16_GATE && TMR8_RST == TMR16_GATE)
        else $error("timer sources differ");
    fuse_active_a: assert property (!FUSE_CFG |-> DETECT_ACTIVE)
        else $error("detector off with fuse clear");
    irq_sticky_a: assert property ($fell(CPU_IRQ) || $fell(IRQ) |->
        WB_ACK_O || $past(WB_ACK_O) || $past(WB_ACK_O, 2))
        else $error("interrupt dropped without a write");
    out_cause_a: assert property (quiet_r >= 3'h5 && $changed(TMR16_GATE) |->
        hist_r[2] != hist_r[3])
        else $error("output moved without input change three cycles before");
    out_read_a: assert property (WB_ACK_O && !WB_WE_I &&
        WB_ADR_I[ADDR_W-1:2] == `ZX_IDX_CTRL |-> WB_DAT_O[5] == $past(TMR16_GATE))
        else $error("control output bit differs from level");

    cpu_irq_c: cover property ($rose(CPU_IRQ));
    irq_c: cover property ($rose(IRQ));
    out_fall_c: cover property ($fell(TMR16_GATE));
endmodule // zx_top_sva

bind zx_top zx_top_sva #(.ADDR_W(ADDR_W)) zx_top_sva_i (.CLK, .ARST_N, .WB_CYC_I,
    .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O,
    .SINK_ACTIVE, .FUSE_CFG, .DETECT_ACTIVE, .TMR16_GATE, .TMR8_CLK, .TMR8_RST,
    .CPU_IRQ, .IRQ);
`default_nettype wire

// ==== zero_cross_event_logic_bench.sv ====
// Self-checking bench for the zero-cross logic
`timescale 1ns/1ps
`default_nettype none
`include "zx_defs.svh"
module zero_cross_event_logic_bench;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [13:0] adr = 14'h0000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic        fuse = 1'b0;
    logic        pin = 1'b0;
    wire  logic [31:0] rdat;
    wire  logic  ack, sink, det, g16, c8, r8, cpu_irq, irq;
    logic [31:0] q;
    int          errors = 0;
    int          check_count = 0;

    always #25 clk = ~clk;

    zx_top zx_top_i (.CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .SINK_ACTIVE(sink), .FUSE_CFG(fuse), .DETECT_ACTIVE(det),
        .TMR16_GATE(g16), .TMR8_CLK(c8), .TMR8_RST(r8), .CPU_IRQ(cpu_irq), .IRQ(irq));
    zx_front_model zx_front_model_i (.clk(clk), .arst_n(arst_n), .pin_above(pin),
        .active(det), .sink(sink));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d,
                      input logic [3:0] s = 4'h1);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        wdat <= {24'h00_0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 8'h00);
        chk(q, exp);
    endtask

    task automatic settle;
        repeat (6) @(posedge clk);
    endtask

    task automatic give_verdict;
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(`ZX_IDX_CTRL, 32'h0);
        rd(`ZX_IDX_FLAG, 32'h0);
        rd(12'h0ecb, 32'h0);
        chk(32'(irq), 32'h0);
        chk(32'(cpu_irq), 32'h0);
        chk(32'(det), 32'h1);
        $display("reset test done");
    endtask

    task automatic t_edges;
        wb(1'b1, `ZX_IDX_ENABLE, 8'h01);
        wb(1'b1, `ZX_IDX_GLOBAL, 8'h03);
        wb(1'b1, `ZX_IDX_MASK, 8'h07);
        wb(1'b1, `ZX_IDX_CTRL, 8'h02);
        @(posedge clk) pin <= 1'b1;
        settle;
        chk(32'(g16), 32'h1);
        chk(32'({c8, r8}), 32'h3);
        chk(32'(cpu_irq), 32'h1);
        rd(`ZX_IDX_STAT, 32'h1);
        rd(`ZX_IDX_FLAG, 32'h1);
        wb(1'b1, `ZX_IDX_FLAG, 8'h01);
        @(posedge clk) pin <= 1'b0;
        settle;
        rd(`ZX_IDX_FLAG, 32'h0);
        rd(`ZX_IDX_STAT, 32'h3);
        chk(32'(irq), 32'h1);
        wb(1'b1, `ZX_IDX_STAT, 8'h07);
        settle;
        chk(32'(irq), 32'h0);
        rd(`ZX_IDX_CTRL, 32'h2);
        $display("edge test done");
    endtask

    task automatic t_pol;
        wb(1'b1, `ZX_IDX_CTRL, 8'h13);
        settle;
        chk(32'(g16), 32'h1);
        rd(`ZX_IDX_CTRL, 32'h33);
        rd(`ZX_IDX_FLAG, 32'h1);
        wb(1'b1, `ZX_IDX_FLAG, 8'h01);
        @(posedge clk) pin <= 1'b1;
        settle;
        chk(32'(g16), 32'h0);
        rd(`ZX_IDX_FLAG, 32'h1);
        wb(1'b1, `ZX_IDX_GLOBAL, 8'h01);
        settle;
        chk(32'(cpu_irq), 32'h0);
        wb(1'b1, `ZX_IDX_GLOBAL, 8'h03);
        settle;
        chk(32'(cpu_irq), 32'h1);
        // Clear taken at the very edge the rise pulse sets the flag
        @(posedge clk) pin <= 1'b0;
        repeat (3) @(posedge clk);
        wb(1'b1, `ZX_IDX_FLAG, 8'h01);
        rd(`ZX_IDX_FLAG, 32'h1);
        @(posedge clk) pin <= 1'b1;
        settle;
        $display("polarity test done");
    endtask

    task automatic t_fuse;
        wb(1'b1, `ZX_IDX_FLAG, 8'h01);
        wb(1'b1, `ZX_IDX_CTRL, 8'h10);
        @(posedge clk) fuse <= 1'b1;
        settle;
        chk(32'(det), 32'h0);
        chk(32'(g16), 32'h1);
        rd(`ZX_IDX_FLAG, 32'h0);
        wb(1'b1, `ZX_IDX_CTRL, 8'h00);
        settle;
        rd(`ZX_IDX_FLAG, 32'h1);
        wb(1'b1, `ZX_IDX_CTRL, 8'h80);
        settle;
        chk(32'(det), 32'h1);
        chk(32'(g16), 32'h1);
        wb(1'b1, `ZX_IDX_CTRL, 8'h13, 4'h0);
        rd(`ZX_IDX_CTRL, 32'ha0);
        wb(1'b1, `ZX_IDX_CTRL, 8'hff);
        settle;
        rd(`ZX_IDX_CTRL, 32'h93);
        $display("fuse test done");
    endtask

    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_reset;
        t_edges;
        t_pol;
        t_fuse;
        give_verdict;
    end

    initial begin
        repeat (4000) @(posedge clk);
        errors++;
        give_verdict;
    end
endmodule // zero_cross_event_logic_bench
`default_nettype wire
